/* rtl/cts_pkg.sv */
// package for the capture timer: register map, field layout, reset values
// assumes a 32-bit avalon-mm slave with byte addresses and one system clock
package cts_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] OFS_MODE    = 5'h00;   // clock, edge and clear selects
    localparam logic [4:0] OFS_PINFN   = 5'h04;   // pin function and filter select
    localparam logic [4:0] OFS_COUNT   = 5'h08;   // live counter value
    localparam logic [4:0] OFS_RISECAP = 5'h0C;   // rising-edge capture
    localparam logic [4:0] OFS_FALLCAP = 5'h10;   // falling-edge capture
    localparam logic [4:0] OFS_STATUS  = 5'h14;   // flag (w1c) and capture level

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int MODE_CSEL_LO = 0;              // count clock select, 2 bits
    localparam int MODE_EDGE    = 2;              // irq edge select, 1 = rising
    localparam int MODE_CLR_LO  = 3;              // counter clear select, 2 bits
    localparam int PIN_SEL      = 0;              // capture pin select
    localparam int PIN_NCS      = 1;              // noise filter select
    localparam int STAT_FLAG    = 0;              // irq request flag
    localparam int STAT_LEVEL   = 1;              // capture signal level

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] MODE_RST  = 8'h00;     // divide-by-64, no clear
    localparam logic [1:0] PINFN_RST = 2'h0;      // port pin, filter off
    localparam logic [7:0] COUNT_RST = 8'h00;     // counter and captures

    ////////////////////////////////////////////////////////////////////////////
    // prescaler taps and the filter depth
    localparam int PRE_WIDTH   = 6;               // free-running system prescaler
    localparam int TAP_DIV64   = 5;
    localparam int TAP_DIV32   = 4;
    localparam int TAP_DIV2    = 0;
    localparam int FILT_STAGES = 5;               // serial sampling latches

    // internal count clock choices
    typedef enum logic [1:0] {
        CSEL_DIV64 = 2'b00,
        CSEL_DIV32 = 2'b01,
        CSEL_DIV2  = 2'b10,
        CSEL_WDIV4 = 2'b11
    } cts_csel_type;

    // counter clear choices
    typedef enum logic [1:0] {
        CLR_NONE = 2'b00,
        CLR_RISE = 2'b01,
        CLR_FALL = 2'b10,
        CLR_BOTH = 2'b11
    } cts_clr_type;

endpackage : cts_pkg

/* rtl/cts_nfilt.sv */
// digital low-pass filter for the capture input: serial latches and a match check
// assumes din is already synchronous to clk and sample_en is a one-cycle pulse
`timescale 1ns/1ps
module cts_nfilt #(
    parameter int STAGES = cts_pkg::FILT_STAGES
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sample_en,   // one-cycle sampling pulse
    input  wire logic preset,      // forces latches and output high
    input  wire logic din,         // synchronised pin level
    output logic      dout         // filtered level
);
    import cts_pkg::*;

    logic [STAGES-1:0] lat_r;      // serial sampling latches
    logic [STAGES-1:0] lat_nxt;    // latches after one sample
    logic              all_eq;     // every latch agrees

    ////////////////////////////////////////////////////////////////////////////
    // shift and match
    assign lat_nxt = {lat_r[STAGES-2:0], din};
    assign all_eq  = (&lat_r) | (~|lat_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lat_r <= '1;
            dout  <= 1'b1;
        end else if (preset) begin
            // filter just switched on: starts from the high state
            lat_r <= '1;
            dout  <= 1'b1;
        end else if (sample_en) begin
            lat_r <= lat_nxt;
            // keep the old value unless all latches agree
            if (all_eq) begin
                dout <= lat_r[STAGES-1];
            end
        end
    end

    // output may only move to a level all latches held, or high on preset
    filt_match_a: assert property (@(posedge clk) disable iff (!resetn)
        ($changed(dout) && !$past(preset)) |-> ($past(all_eq) && $past(sample_en)))
        else $error("filter output moved without agreement");

endmodule : cts_nfilt

/* rtl/cts_timer.sv */
// 8-bit capture/interval timer: prescaler, clock switching, pin gating, capture
// assumes avalon-mm master with waitrequest; capture and watch clock pins async
// Function
// - count once per selected clock falling edge
// - select write high-to-low counts one increment
// - pin select set, pin high: rising edge
// - pin select cleared, pin high: falling edge
// - filter on, pin high, select early: rising
// - filter on, pin low, select early: falling
// - filter on, pin high, deselect late: falling
// - capture signal low when pin not selected
// - pin rises, filter on early: rising edge
// - pin falls, filter off early: falling edge
// - spurious matching edge sets the request flag
// - clear select both: clear on both edges
// - edges copy counter into capture registers
// - filter output moves only when latches agree, or goes high on filter enable
// - two-bit select picks one of four clocks
`timescale 1ns/1ps
module cts_timer (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        CAPTURE_PIN,
    input  wire logic        WATCH_CLK,
    output logic             IRQ_FLAG,
    output logic [7:0]       COUNT_VALUE
);
    import cts_pkg::*;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic                 ack_r;          // one wait state done
    logic                 wr_go;          // write accepted this edge
    logic                 rd_go;          // read request, first cycle
    logic [31:0]          rd_mux;         // selected read word
    logic [7:0]           mode_r;         // mode register
    logic [1:0]           pinfn_r;        // pin function register
    cts_csel_type         csel;           // count clock choice
    cts_clr_type          clr_sel;        // counter clear choice
    logic                 edge_sel;       // 1 = rising edge requests
    logic                 pin_sel;        // pin used as capture input
    logic                 noise_filter_select;            // filter in use
    logic                 ncs_q_r;        // filter select one cycle ago
    logic [PRE_WIDTH-1:0] pre_r;          // system prescaler
    logic [1:0]           cap_sync_r;     // capture pin synchroniser
    logic [1:0]           wclk_sync_r;    // watch clock synchroniser
    logic                 wclk_q_r;       // watch clock previous level
    logic [1:0]           wdiv_r;         // watch clock divide-by-four
    logic [3:0]           src_lvl;        // the four divided levels
    logic                 sel_lvl;        // selected level now
    logic                 sel_lvl_r;      // selected level last cycle
    logic                 inc;            // counter increment pulse
    logic                 samp_en;        // filter sampling pulse
    logic                 filt_out;       // filtered pin level
    logic                 cap;            // internal capture signal
    logic                 cap_r;          // capture signal last cycle
    logic                 cap_rise;       // rising edge of capture signal
    logic                 cap_fall;       // falling edge of capture signal
    logic                 clr;            // counter clear this cycle
    logic [7:0]           cnt_r;          // the capture counter
    logic [7:0]           cnt_nxt;        // counter next value
    logic [7:0]           rcap_r;         // rising capture register
    logic [7:0]           fcap_r;         // falling capture register
    logic                 flag_set;       // edge matched the selection
    logic                 flag_clr;       // software write-one-to-clear
    logic                 flag_r;         // interrupt request flag

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state on every access
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
    assign wr_go           = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
    assign rd_go           = AVS_READ & ~ack_r;

    // unmapped offsets read zero, writes there are dropped
    assign rd_mux = (AVS_ADDRESS == OFS_MODE)    ? {24'h00_0000, mode_r} :
                    (AVS_ADDRESS == OFS_PINFN)   ? {30'h0000_0000, pinfn_r} :
                    (AVS_ADDRESS == OFS_COUNT)   ? {24'h00_0000, cnt_r} :
                    (AVS_ADDRESS == OFS_RISECAP) ? {24'h00_0000, rcap_r} :
                    (AVS_ADDRESS == OFS_FALLCAP) ? {24'h00_0000, fcap_r} :
                    (AVS_ADDRESS == OFS_STATUS)  ? {30'h0000_0000, cap, flag_r} :
                    32'h0000_0000;

    // wait-state tracker and read data register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_r        <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
            if (rd_go) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    // select write lands at the accepting edge
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_r  <= MODE_RST;
            pinfn_r <= PINFN_RST;
        end else if (wr_go) begin
            if (AVS_ADDRESS == OFS_MODE) begin
                mode_r <= {3'h0, AVS_WRITEDATA[4:0]};
            end
            if (AVS_ADDRESS == OFS_PINFN) begin
                pinfn_r <= AVS_WRITEDATA[1:0];
            end
        end
    end

    // field decode
    assign csel     = cts_csel_type'(mode_r[MODE_CSEL_LO +: 2]);
    assign clr_sel  = cts_clr_type'(mode_r[MODE_CLR_LO +: 2]);
    assign edge_sel = mode_r[MODE_EDGE];
    assign pin_sel  = pinfn_r[PIN_SEL];
    assign noise_filter_select      = pinfn_r[PIN_NCS];

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and clock sources
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cap_sync_r  <= 2'h0;
            wclk_sync_r <= 2'h0;
            wclk_q_r    <= 1'b0;
            wdiv_r      <= 2'h0;
            pre_r       <= '0;
        end else begin
            cap_sync_r  <= {cap_sync_r[0], CAPTURE_PIN};
            wclk_sync_r <= {wclk_sync_r[0], WATCH_CLK};
            wclk_q_r    <= wclk_sync_r[1];
            pre_r       <= pre_r + 1'b1;
            // watch clock divided by four on its synchronised rising edges
            if (wclk_sync_r[1] & ~wclk_q_r) begin
                wdiv_r <= wdiv_r + 2'h1;
            end
        end
    end

    assign src_lvl = {wdiv_r[1], pre_r[TAP_DIV2], pre_r[TAP_DIV32], pre_r[TAP_DIV64]};
    assign sel_lvl = src_lvl[csel];

    // falling edge of the selected level
    // a switch from high to low also counts
    assign inc = sel_lvl_r & ~sel_lvl;

    // filter samples each cycle when off, on selected rising edges when on
    assign samp_en = noise_filter_select ? (sel_lvl & ~sel_lvl_r) : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // noise filter
    // preset on enable makes early select rise
    // low pin then decays: falling edge
    cts_nfilt #(
        .STAGES    (FILT_STAGES)
    ) u_nfilt (
        .clk       (CLK),
        .resetn    (RESETN),
        .sample_en (samp_en),
        .preset    (noise_filter_select & ~ncs_q_r),
        .din       (cap_sync_r[1]),
        .dout      (filt_out)
    );

    // direct path, select set while high
    // select cleared on high: falling edge
    assign cap = pin_sel & (noise_filter_select ? filt_out : cap_sync_r[1]);

    ////////////////////////////////////////////////////////////////////////////
    // edge detection, clear and flag terms
    assign cap_rise = cap & ~cap_r;
    assign cap_fall = ~cap & cap_r;

    // clear on chosen edge, both when 11
    assign clr = (cap_rise & clr_sel[0]) | (cap_fall & clr_sel[1]);

    // clear beats increment
    assign cnt_nxt = clr ? COUNT_RST : (inc ? cnt_r + 8'h01 : cnt_r);

    assign flag_set = edge_sel ? cap_rise : cap_fall;
    assign flag_clr = wr_go & (AVS_ADDRESS == OFS_STATUS) & AVS_WRITEDATA[STAT_FLAG];

    // edge history and the selected clock level
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cap_r     <= 1'b0;
            sel_lvl_r <= 1'b0;
            ncs_q_r   <= 1'b0;
        end else begin
            cap_r     <= cap;
            sel_lvl_r <= sel_lvl;
            ncs_q_r   <= noise_filter_select;
        end
    end

    // counter
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_r <= COUNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rcap_r <= COUNT_RST;
            fcap_r <= COUNT_RST;
        end else begin
            if (cap_rise) begin
                rcap_r <= cnt_r;
            end
            if (cap_fall) begin
                fcap_r <= cnt_r;
            end
        end
    end

    // request flag: a new edge wins over a clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_r <= 1'b0;
        end else if (flag_set) begin
            flag_r <= 1'b1;
        end else if (flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    assign IRQ_FLAG    = flag_r;
    assign COUNT_VALUE = cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    count_step_a: assert property (
        (inc && !clr) |=> (cnt_r == $past(cnt_r) + 8'h01))
        else $error("counter missed an increment");

    sel_switch_a: assert property (
        ($changed(csel) && sel_lvl_r && !sel_lvl) |=> (cnt_r != $past(cnt_r)) || $past(clr))
        else $error("high-to-low switch did not count");

    pin_rise_a: assert property (
        ($rose(pin_sel) && !noise_filter_select && cap_sync_r[1]) |-> cap_rise)
        else $error("select set on high pin gave no rising edge");

    pin_fall_a: assert property (
        ($fell(pin_sel) && cap_r) |-> cap_fall ##1 !cap)
        else $error("select cleared on high signal gave no falling edge");

    gate_low_a: assert property (
        !pin_sel |-> (!cap ##1 (!cap_r || pin_sel)))
        else $error("capture signal high while pin not selected");

    filt_off_a: assert property (
        ($fell(noise_filter_select) && pin_sel && filt_out && !cap_sync_r[1]) |-> cap_fall)
        else $error("filter off on low pin gave no falling edge");

    flag_edge_a: assert property (
        ((edge_sel && cap_rise) || (!edge_sel && cap_fall)) |=> flag_r)
        else $error("matching edge did not set the flag");

    both_clear_a: assert property (
        (clr_sel == CLR_BOTH && (cap_rise || cap_fall)) |=> (cnt_r == 8'h00))
        else $error("both-edge clear missed");

    rise_copy_a: assert property (
        cap_rise |=> (rcap_r == $past(cnt_r)) ##1 (fcap_r == $past(fcap_r) || $past(cap_fall)))
        else $error("rising capture lost the counter value");

    fall_copy_a: assert property (
        cap_fall |=> (fcap_r == $past(cnt_r)))
        else $error("falling capture lost the counter value");

    filt_preset_a: assert property (
        $rose(noise_filter_select) |=> filt_out)
        else $error("filter enable did not preset the output high");

endmodule : cts_timer

/* bench/cts_pulse_src.sv */
// external pulse source that drives the capture pin
// assumes the bench calls set_level right after a rising clk edge
`timescale 1ns/1ps
module cts_pulse_src (
    input  wire logic clk,   // system clock, paces callers
    output logic      pin    // capture pin level
);
    // pin idles low until the bench drives it
    initial pin = 1'b0;

    // drive a static level, changed only after an edge
    task automatic set_level(input logic v);
        pin <= v;
    endtask : set_level
endmodule : cts_pulse_src

/* bench/capture_timer_switch_effects_tb.sv */
// self-checking bench for the capture timer: bus, clock switching, pin and filter edges
// assumes the pulse source model and the register map of cts_pkg
`timescale 1ns/1ps
module capture_timer_switch_effects_tb;
    import cts_pkg::*;
    logic        clk = 1'b0;            // system clock
    logic        resetn;                // async reset, active low
    logic [4:0]  avs_address;           // bus address
    logic        avs_read;              // read strobe
    logic        avs_write;             // write strobe
    logic [3:0]  avs_byteenable;        // byte lanes of the access
    logic [31:0] avs_writedata;         // write data
    logic [31:0] avs_readdata;          // read data
    logic        avs_waitrequest;       // slave stall
    logic        watch_clk = 1'b0;      // slow watch clock
    logic        cap_pin;               // capture pin from source
    logic        irq_flag;              // request flag
    logic [7:0]  count_value;           // live counter
    logic [31:0] rd;                    // last read data
    int          mismatches = 0;
    int          n_compared = 0;
    int          divs [4] = '{64, 32, 2, 80};  // cycles per count for each select

    // system clock, 4 ns period
    always #2 clk = ~clk;
    // watch clock, 80 ns period
    always #40 watch_clk = ~watch_clk;

    cts_timer cts_timer_inst (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .CAPTURE_PIN(cap_pin),
        .WATCH_CLK(watch_clk), .IRQ_FLAG(irq_flag), .COUNT_VALUE(count_value));
    cts_pulse_src cts_pulse_src_inst (.clk(clk), .pin(cap_pin));

    ////////////////////////////////////////////////////////////////////////////
    // compare, count, report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // range compare on a read value
    task automatic inrange(input logic [31:0] v, input int lo, input int hi, input string what);
        check({31'h0000_0000, (v >= lo && v <= hi)}, 32'h0000_0001, what);
    endtask : inrange

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        // held until the edge that samples waitrequest low; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 8'h00, 4'hF);
        check(rd, exp, what);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////
    // reset values, read-only bits, unmapped place
    task automatic t_reset();
        rdchk(OFS_COUNT, 32'h0000_0000, "count after reset");
        rdchk(OFS_MODE, 32'h0000_0000, "mode after reset");
        rdchk(OFS_PINFN, 32'h0000_0000, "pinfn after reset");
        rdchk(OFS_STATUS, 32'h0000_0000, "status after reset");
        wr(5'h18, 8'hFF);
        rdchk(5'h18, 32'h0000_0000, "unmapped read");
        wr(OFS_MODE, 8'hFF);
        rdchk(OFS_MODE, 32'h0000_001F, "mode upper bits");
        wr(OFS_MODE, 8'h00);
        // lane 0 disabled: write dropped
        bus(1'b1, OFS_MODE, 8'h1F, 4'h0);
        rdchk(OFS_MODE, 32'h0000_0000, "masked write dropped");
    endtask : t_reset

    // pin select changes with the pin high
    task automatic t_pin();
        cts_pulse_src_inst.set_level(1'b1);
        repeat (4) @(posedge clk);
        rdchk(OFS_STATUS, 32'h0000_0000, "unselected level");
        wr(OFS_MODE, 8'h04);
        wr(OFS_PINFN, 8'h01);
        rdchk(OFS_STATUS, 32'h0000_0003, "select rising");
        check({31'h0000_0000, irq_flag}, 32'h0000_0001, "flag pin rising");
        bus(1'b0, OFS_RISECAP, 8'h00, 4'hF);
        check({24'h00_0000, count_value} - rd <= 1, 32'h0000_0001, "rise capture");
        wr(OFS_STATUS, 8'h01);
        wr(OFS_PINFN, 8'h00);
        rdchk(OFS_STATUS, 32'h0000_0000, "deselect no flag");
        wr(OFS_MODE, 8'h00);
        wr(OFS_PINFN, 8'h01);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_PINFN, 8'h00);
        rdchk(OFS_STATUS, 32'h0000_0001, "deselect falling");
        wr(OFS_STATUS, 8'h01);
        cts_pulse_src_inst.set_level(1'b0);
    endtask : t_pin

    // all four count clocks, ten counts each
    task automatic t_clksel();
        logic [31:0] c0;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_MODE, i[7:0]);
            bus(1'b0, OFS_COUNT, 8'h00, 4'hF);
            c0 = rd;
            // two bus edges and the gap edge complete the span of ten periods
            repeat (10 * divs[i] - 3) @(posedge clk);
            bus(1'b0, OFS_COUNT, 8'h00, 4'hF);
            inrange((rd - c0) & 32'h0000_00FF, 9, 11, "count rate");
        end
    endtask : t_clksel

    // switch from a high divide-by-64 level to a low divide-by-32 level
    task automatic t_switch();
        logic [7:0] c;
        wr(OFS_MODE, 8'h00);
        c = count_value;
        // align to a fresh divide-by-64 increment
        while (count_value === c) begin
            @(posedge clk);
        end
        c = count_value;
        repeat (34) @(posedge clk);
        wr(OFS_MODE, 8'h01);
        repeat (3) @(posedge clk);
        check({24'h00_0000, count_value}, {24'h00_0000, c + 8'h01}, "switch increment");
    endtask : t_switch

    // filter enable and pin select interplay, divide-by-2 sampling
    task automatic t_filter();
        wr(OFS_MODE, 8'h02);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_PINFN, 8'h02);
        wr(OFS_PINFN, 8'h03);
        rdchk(OFS_STATUS, 32'h0000_0002, "early select pin low");
        repeat (30) @(posedge clk);
        rdchk(OFS_STATUS, 32'h0000_0001, "filter settles low");
        wr(OFS_STATUS, 8'h01);
        cts_pulse_src_inst.set_level(1'b1);
        repeat (6) @(posedge clk);
        cts_pulse_src_inst.set_level(1'b0);
        repeat (20) @(posedge clk);
        rdchk(OFS_STATUS, 32'h0000_0000, "short pulse dropped");
        cts_pulse_src_inst.set_level(1'b1);
        repeat (20) @(posedge clk);
        rdchk(OFS_STATUS, 32'h0000_0002, "long pulse passed");
        // select cleared before the filter bit
        wr(OFS_PINFN, 8'h02);
        wr(OFS_PINFN, 8'h00);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_MODE, 8'h06);
        wr(OFS_PINFN, 8'h02);
        wr(OFS_PINFN, 8'h03);
        rdchk(OFS_STATUS, 32'h0000_0003, "early select pin high");
        // flag left alone until five sampling clocks have passed
        repeat (10) @(posedge clk);
        check({31'h0000_0000, irq_flag}, 32'h0000_0001, "flag held over settle");
        wr(OFS_STATUS, 8'h01);
        check({31'h0000_0000, irq_flag}, 32'h0000_0000, "flag cleared after settle");
        repeat (20) @(posedge clk);
        wr(OFS_MODE, 8'h02);
        wr(OFS_PINFN, 8'h02);
        rdchk(OFS_STATUS, 32'h0000_0001, "late deselect falling");
        wr(OFS_PINFN, 8'h00);
        wr(OFS_STATUS, 8'h01);
        cts_pulse_src_inst.set_level(1'b0);
    endtask : t_filter

    // filter switched with the pin selected: rise then filter on, fall then filter off
    task automatic t_noise_sw();
        wr(OFS_MODE, 8'h06);
        wr(OFS_PINFN, 8'h01);
        cts_pulse_src_inst.set_level(1'b1);
        wr(OFS_PINFN, 8'h03);
        repeat (2) @(posedge clk);
        rdchk(OFS_STATUS, 32'h0000_0003, "pin rise then filter on");
        wr(OFS_MODE, 8'h02);
        wr(OFS_STATUS, 8'h01);
        cts_pulse_src_inst.set_level(1'b0);
        wr(OFS_PINFN, 8'h01);
        rdchk(OFS_STATUS, 32'h0000_0001, "pin fall then filter off");
        wr(OFS_PINFN, 8'h00);
        wr(OFS_STATUS, 8'h01);
    endtask : t_noise_sw

    // clear on both edges measures high and low widths
    task automatic t_both();
        wr(OFS_MODE, 8'h1A);
        wr(OFS_PINFN, 8'h01);
        repeat (10) @(posedge clk);
        cts_pulse_src_inst.set_level(1'b1);
        repeat (40) @(posedge clk);
        cts_pulse_src_inst.set_level(1'b0);
        repeat (60) @(posedge clk);
        cts_pulse_src_inst.set_level(1'b1);
        repeat (10) @(posedge clk);
        bus(1'b0, OFS_FALLCAP, 8'h00, 4'hF);
        inrange(rd, 19, 21, "high width");
        bus(1'b0, OFS_RISECAP, 8'h00, 4'hF);
        inrange(rd, 29, 31, "low width");
        bus(1'b0, OFS_COUNT, 8'h00, 4'hF);
        inrange(rd, 4, 12, "cleared at rise");
    endtask : t_both

    ////////////////////////////////////////////////////////////////////////////
    // counts, verdict, end of run
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // main sequence
    initial begin
        resetn <= 1'b0;
        avs_address <= 5'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_byteenable <= 4'h0;
        avs_writedata <= 32'h0000_0000;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pin();
        t_clksel();
        t_switch();
        t_filter();
        t_noise_sw();
        t_both();
        give_verdict();
    end
endmodule : capture_timer_switch_effects_tb
